// ### hdl/caa_defines.svh
// Offsets, field positions, reset values and widths for the control access arbiter
`ifndef CAA_DEFINES_SVH
`define CAA_DEFINES_SVH

`define CAA_PARAM_AW 16
`define CAA_PARAM_DW 16
`define CAA_OFS_OTHER_CHANNEL_BLOCK 16'h013c
`define CAA_OFS_PANEL_BLOCK 16'h3a02
`define CAA_RST_OTHER_CHANNEL_BLOCK 16'h0000
`define CAA_RST_PANEL_BLOCK 16'h0000
`define CAA_BLOCK_BIT 0

`endif

// ### hdl/caa_pkg.sv
// Types shared by the control access arbiter and its mode map
package caa_pkg;

  typedef enum logic [1:0]
  {
    CAA_SRC_PANEL = 2'b00,
    CAA_SRC_TOOL = 2'b01,
    CAA_SRC_FB = 2'b10,
    CAA_SRC_FB2 = 2'b11
  } caa_src_t;

  typedef enum logic [2:0]
  {
    CAA_OWN_NONE = 3'b000,
    CAA_OWN_PANEL = 3'b001,
    CAA_OWN_TOOL = 3'b010,
    CAA_OWN_FB = 3'b011,
    CAA_OWN_FB2 = 3'b100
  } caa_owner_t;

  typedef enum logic [2:0]
  {
    CAA_MODE_JOG = 3'b000,
    CAA_MODE_CURRENT = 3'b001,
    CAA_MODE_SPEED = 3'b010,
    CAA_MODE_GEAR = 3'b011,
    CAA_MODE_PROF_POS = 3'b100,
    CAA_MODE_PROF_VEL = 3'b101,
    CAA_MODE_HOMING = 3'b110,
    CAA_MODE_NONE = 3'b111
  } caa_mode_t;

  typedef enum logic [1:0]
  {
    CAA_LOOP_NONE = 2'b00,
    CAA_LOOP_CURRENT = 2'b01,
    CAA_LOOP_SPEED = 2'b10,
    CAA_LOOP_POSITION = 2'b11
  } caa_loop_t;

  typedef enum logic [1:0]
  {
    CAA_REF_NONE = 2'b00,
    CAA_REF_FIELDBUS = 2'b01,
    CAA_REF_PANEL = 2'b10,
    CAA_REF_PULSE_INPUTS = 2'b11
  } caa_ref_t;

endpackage

// ### hdl/caa_mode_map.sv
// Operating mode to control loop, profile generator and reference source
`timescale 1ns/1ps

module caa_mode_map
  import caa_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst_n,
  input caa_pkg::caa_mode_t i_mode,
  input wire logic i_fieldbus_mode,
  input wire logic i_panel_owns,
  output caa_pkg::caa_loop_t o_loop,
  output logic o_profile_gen,
  output caa_pkg::caa_ref_t o_ref_src
);
  import caa_pkg::*;

  caa_loop_t loop_r;
  caa_loop_t loop_nxt;
  logic prof_r;
  logic prof_nxt;
  caa_ref_t ref_r;
  caa_ref_t ref_nxt;

  always_comb
  begin
    loop_nxt = CAA_LOOP_NONE;
    prof_nxt = 1'b0;
    ref_nxt = CAA_REF_NONE;
    case (i_mode)
      CAA_MODE_CURRENT:
      begin
        loop_nxt = CAA_LOOP_CURRENT;
      end
      CAA_MODE_SPEED:
      begin
        loop_nxt = CAA_LOOP_SPEED;
      end
      CAA_MODE_GEAR:
      begin
        loop_nxt = CAA_LOOP_POSITION;
      end
      CAA_MODE_JOG, CAA_MODE_PROF_POS, CAA_MODE_PROF_VEL, CAA_MODE_HOMING:
      begin
        loop_nxt = CAA_LOOP_POSITION;
        prof_nxt = 1'b1;
      end
      default:
      begin
        loop_nxt = CAA_LOOP_NONE;
      end
    endcase
    // Source table only defined for fieldbus control mode
    if (i_fieldbus_mode && (i_mode != CAA_MODE_NONE))
    begin
      if (i_mode == CAA_MODE_JOG)
      begin
        ref_nxt = i_panel_owns ? CAA_REF_PANEL : CAA_REF_FIELDBUS;
      end
      else if (i_mode == CAA_MODE_GEAR)
      begin
        ref_nxt = CAA_REF_PULSE_INPUTS;
      end
      else
      begin
        ref_nxt = CAA_REF_FIELDBUS;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      loop_r <= CAA_LOOP_NONE;
      prof_r <= 1'b0;
      ref_r <= CAA_REF_NONE;
    end
    else
    begin
      loop_r <= loop_nxt;
      prof_r <= prof_nxt;
      ref_r <= ref_nxt;
    end
  end

  assign o_loop = loop_r;
  assign o_profile_gen = prof_r;
  assign o_ref_src = ref_r;

endmodule // caa_mode_map

// ### hdl/caa_arbiter.sv
// Control access arbiter: channel ownership, lock parameters and safety input pass-through
`timescale 1ns/1ps
`include "caa_defines.svh"

module caa_arbiter
  import caa_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_fieldbus_mode,
  input wire logic i_acq_valid,
  input caa_pkg::caa_src_t i_acq_src,
  input wire logic i_rel_valid,
  input caa_pkg::caa_src_t i_rel_src,
  input wire logic i_cmd_valid,
  input caa_pkg::caa_src_t i_cmd_src,
  input wire logic i_cmd_write,
  input wire logic [`CAA_PARAM_AW-1:0] i_cmd_addr,
  input wire logic [`CAA_PARAM_DW-1:0] i_cmd_wdata,
  input caa_pkg::caa_mode_t i_mode,
  input wire logic i_halt,
  input wire logic i_power_removal_in_first,
  input wire logic i_power_removal_in_second,
  input wire logic i_stop,
  output logic o_acq_grant,
  output logic o_acq_refused,
  output logic o_cmd_ack,
  output logic o_cmd_refused,
  output logic [`CAA_PARAM_DW-1:0] o_cmd_rdata,
  output logic o_fwd_valid,
  output logic [`CAA_PARAM_AW-1:0] o_fwd_addr,
  output logic [`CAA_PARAM_DW-1:0] o_fwd_wdata,
  output caa_pkg::caa_owner_t o_owner,
  output logic o_lock_active,
  output logic [`CAA_PARAM_DW-1:0] o_other_channel_block,
  output logic [`CAA_PARAM_DW-1:0] o_panel_block,
  output logic o_halt,
  output logic o_power_removal,
  output logic o_stop,
  output caa_pkg::caa_loop_t o_loop,
  output logic o_profile_gen,
  output caa_pkg::caa_ref_t o_ref_src
);
  import caa_pkg::*;

  localparam int DW = `CAA_PARAM_DW;
  localparam int AW = `CAA_PARAM_AW;

  function automatic caa_owner_t src_to_owner(input caa_src_t src);
    case (src)
      CAA_SRC_PANEL: src_to_owner = CAA_OWN_PANEL;
      CAA_SRC_TOOL: src_to_owner = CAA_OWN_TOOL;
      CAA_SRC_FB: src_to_owner = CAA_OWN_FB;
      default: src_to_owner = CAA_OWN_FB2;
    endcase
  endfunction

  // Shared gate for acquires and control writes
  function automatic logic src_blocked(input caa_src_t src, input caa_owner_t own,
    input logic lock, input logic panel_lk);
    logic blk;
    blk = 1'b0;
    if (lock && (src != CAA_SRC_FB))
    begin
      blk = 1'b1;
    end
    if ((own != CAA_OWN_NONE) && (own != src_to_owner(src)))
    begin
      blk = 1'b1;
    end
    if ((src == CAA_SRC_PANEL) && panel_lk)
    begin
      blk = 1'b1;
    end
    src_blocked = blk;
  endfunction

  // Register select shared by reads and writes
  function automatic logic [1:0] reg_sel(input logic [AW-1:0] addr);
    logic [1:0] sel;
    sel = 2'h0;
    if (addr == `CAA_OFS_OTHER_CHANNEL_BLOCK)
    begin
      sel = 2'h1;
    end
    else if (addr == `CAA_OFS_PANEL_BLOCK)
    begin
      sel = 2'h2;
    end
    reg_sel = sel;
  endfunction

  caa_owner_t owner_r;
  caa_owner_t owner_nxt;
  logic [DW-1:0] ocb_r;
  logic [DW-1:0] ocb_nxt;
  logic [DW-1:0] pb_r;
  logic [DW-1:0] pb_nxt;
  logic acq_grant_r;
  logic acq_grant_nxt;
  logic acq_ref_r;
  logic acq_ref_nxt;
  logic ack_r;
  logic ack_nxt;
  logic cref_r;
  logic cref_nxt;
  logic [DW-1:0] rdata_r;
  logic [DW-1:0] rdata_nxt;
  logic fwd_v_r;
  logic fwd_v_nxt;
  logic [AW-1:0] fwd_a_r;
  logic [AW-1:0] fwd_a_nxt;
  logic [DW-1:0] fwd_d_r;
  logic [DW-1:0] fwd_d_nxt;
  logic halt_r;
  logic pwr_r;
  logic stop_r;
  logic lock_active;
  logic panel_locked;
  caa_owner_t own_after_rel;

  // Lock only counts while the device runs under fieldbus control
  assign lock_active = ocb_r[`CAA_BLOCK_BIT] && i_fieldbus_mode;
  assign panel_locked = pb_r[`CAA_BLOCK_BIT];

  always_comb
  begin
    owner_nxt = owner_r;
    acq_grant_nxt = 1'b0;
    acq_ref_nxt = 1'b0;
    own_after_rel = owner_r;
    // Release by the holder ends its function
    if (i_rel_valid && (src_to_owner(i_rel_src) == owner_r))
    begin
      own_after_rel = CAA_OWN_NONE;
    end
    owner_nxt = own_after_rel;
    if (i_acq_valid)
    begin
      if (src_blocked(i_acq_src, owner_r, lock_active, panel_locked))
      begin
        acq_ref_nxt = 1'b1;
      end
      else
      begin
        owner_nxt = src_to_owner(i_acq_src);
        acq_grant_nxt = 1'b1;
      end
    end
    // Owner blocked by a new lock loses access
    if (lock_active && (owner_nxt != CAA_OWN_NONE) && (owner_nxt != CAA_OWN_FB))
    begin
      owner_nxt = CAA_OWN_NONE;
    end
  end

  always_comb
  begin
    ocb_nxt = ocb_r;
    pb_nxt = pb_r;
    ack_nxt = 1'b0;
    cref_nxt = 1'b0;
    rdata_nxt = rdata_r;
    fwd_v_nxt = 1'b0;
    fwd_a_nxt = fwd_a_r;
    fwd_d_nxt = fwd_d_r;
    if (i_cmd_valid && !i_cmd_write)
    begin
      // Monitoring reads are never refused
      ack_nxt = 1'b1;
      if (reg_sel(i_cmd_addr) == 2'h1)
      begin
        rdata_nxt = ocb_r;
      end
      else if (reg_sel(i_cmd_addr) == 2'h2)
      begin
        rdata_nxt = pb_r;
      end
      else
      begin
        rdata_nxt = '0;
      end
    end
    else if (i_cmd_valid)
    begin
      if (src_blocked(i_cmd_src, owner_r, lock_active, panel_locked))
      begin
        cref_nxt = 1'b1;
      end
      else if (reg_sel(i_cmd_addr) == 2'h1)
      begin
        // Only a fieldbus may set or clear the exclusive lock
        if ((i_cmd_src == CAA_SRC_FB) || (i_cmd_src == CAA_SRC_FB2))
        begin
          ocb_nxt = i_cmd_wdata;
          ack_nxt = 1'b1;
        end
        else
        begin
          cref_nxt = 1'b1;
        end
      end
      else if (reg_sel(i_cmd_addr) == 2'h2)
      begin
        pb_nxt = i_cmd_wdata;
        ack_nxt = 1'b1;
      end
      else
      begin
        ack_nxt = 1'b1;
        fwd_v_nxt = 1'b1;
        fwd_a_nxt = i_cmd_addr;
        fwd_d_nxt = i_cmd_wdata;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      owner_r <= CAA_OWN_NONE;
      ocb_r <= `CAA_RST_OTHER_CHANNEL_BLOCK;
      pb_r <= `CAA_RST_PANEL_BLOCK;
      acq_grant_r <= 1'b0;
      acq_ref_r <= 1'b0;
      ack_r <= 1'b0;
      cref_r <= 1'b0;
      rdata_r <= '0;
      fwd_v_r <= 1'b0;
      fwd_a_r <= '0;
      fwd_d_r <= '0;
    end
    else
    begin
      owner_r <= owner_nxt;
      ocb_r <= ocb_nxt;
      pb_r <= pb_nxt;
      acq_grant_r <= acq_grant_nxt;
      acq_ref_r <= acq_ref_nxt;
      ack_r <= ack_nxt;
      cref_r <= cref_nxt;
      rdata_r <= rdata_nxt;
      fwd_v_r <= fwd_v_nxt;
      fwd_a_r <= fwd_a_nxt;
      fwd_d_r <= fwd_d_nxt;
    end
  end

  // Safety inputs bypass ownership and locks entirely
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      halt_r <= 1'b0;
      pwr_r <= 1'b0;
      stop_r <= 1'b0;
    end
    else
    begin
      halt_r <= i_halt;
      pwr_r <= i_power_removal_in_first | i_power_removal_in_second;
      stop_r <= i_stop;
    end
  end

  caa_mode_map u_mode_map
  (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_mode(i_mode),
    .i_fieldbus_mode(i_fieldbus_mode),
    .i_panel_owns(owner_r == CAA_OWN_PANEL),
    .o_loop(o_loop),
    .o_profile_gen(o_profile_gen),
    .o_ref_src(o_ref_src)
  );

  assign o_acq_grant = acq_grant_r;
  assign o_acq_refused = acq_ref_r;
  assign o_cmd_ack = ack_r;
  assign o_cmd_refused = cref_r;
  assign o_cmd_rdata = rdata_r;
  assign o_fwd_valid = fwd_v_r;
  assign o_fwd_addr = fwd_a_r;
  assign o_fwd_wdata = fwd_d_r;
  assign o_owner = owner_r;
  assign o_lock_active = lock_active;
  assign o_other_channel_block = ocb_r;
  assign o_panel_block = pb_r;
  assign o_halt = halt_r;
  assign o_power_removal = pwr_r;
  assign o_stop = stop_r;

endmodule // caa_arbiter

// ### testbench/caa_properties.sv
// Port assertions for the control access arbiter
`timescale 1ns/1ps
`include "caa_defines.svh"
module caa_properties
  import caa_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_fieldbus_mode,
  input wire logic i_acq_valid,
  input caa_pkg::caa_src_t i_acq_src,
  input caa_pkg::caa_mode_t i_mode,
  input wire logic i_halt,
  input wire logic i_power_removal_in_first,
  input wire logic i_power_removal_in_second,
  input wire logic i_stop,
  input wire logic o_acq_grant,
  input wire logic o_acq_refused,
  input caa_pkg::caa_owner_t o_owner,
  input wire logic o_lock_active,
  input wire logic [`CAA_PARAM_DW-1:0] o_other_channel_block,
  input wire logic [`CAA_PARAM_DW-1:0] o_panel_block,
  input wire logic o_halt,
  input wire logic o_power_removal,
  input wire logic o_stop,
  input caa_pkg::caa_loop_t o_loop
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);
  // First edge after reset still sees inputs from reset time
  chk_safety_pass: assert property (
    $past(i_rst_n) |-> o_halt == $past(i_halt) && o_stop == $past(i_stop)
      && o_power_removal == ($past(i_power_removal_in_first) | $past(i_power_removal_in_second)))
    else $error("safety input not passed");
  chk_lock_level: assert property (
    o_lock_active == (o_other_channel_block[`CAA_BLOCK_BIT] && i_fieldbus_mode))
    else $error("lock level wrong");
  chk_lock_owner: assert property (
    o_lock_active |=> o_owner inside {CAA_OWN_NONE, CAA_OWN_FB})
    else $error("owner kept under lock");
  chk_lock_refuse: assert property (
    o_lock_active && i_acq_valid && i_acq_src != CAA_SRC_FB |=> o_acq_refused)
    else $error("locked channel granted");
  chk_acq_answer: assert property (
    i_acq_valid |=> o_acq_grant != o_acq_refused)
    else $error("acquire not answered once");
  chk_tool_hold: assert property (
    o_owner == CAA_OWN_TOOL && i_acq_valid && i_acq_src != CAA_SRC_TOOL |=> o_acq_refused)
    else $error("tool access taken");
  chk_panel_hold: assert property (
    o_owner == CAA_OWN_PANEL && i_acq_valid && i_acq_src != CAA_SRC_PANEL |=> o_acq_refused)
    else $error("panel access taken");
  chk_panel_lock: assert property (
    i_acq_valid && i_acq_src == CAA_SRC_PANEL && o_panel_block[`CAA_BLOCK_BIT] |=> o_acq_refused)
    else $error("blocked panel granted");
  chk_mode_loop: assert property (
    i_mode == CAA_MODE_CURRENT |=> o_loop == CAA_LOOP_CURRENT)
    else $error("current loop not chosen");
  cover property (o_acq_grant && o_owner == CAA_OWN_TOOL);
  cover property (o_lock_active);
  cover property (o_acq_refused);
endmodule // caa_properties

bind caa_arbiter caa_properties i_caa_properties (.*);

// ### testbench/caa_channels.sv
// Requesting channels: panel, tool and fieldbus
`timescale 1ns/1ps
module caa_channels
  import caa_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_grant,
  input wire logic i_refused,
  input wire logic i_ack,
  input wire logic i_cmd_refused,
  input wire logic [15:0] i_rdata,
  output logic o_acq_valid,
  output caa_pkg::caa_src_t o_acq_src,
  output logic o_rel_valid,
  output caa_pkg::caa_src_t o_rel_src,
  output logic o_cmd_valid,
  output caa_pkg::caa_src_t o_cmd_src,
  output logic o_cmd_write,
  output logic [15:0] o_cmd_addr,
  output logic [15:0] o_cmd_wdata
);
  initial
  begin
    {o_acq_valid, o_rel_valid, o_cmd_valid, o_cmd_write} = 4'h0;
    o_acq_src = CAA_SRC_PANEL;
    o_rel_src = CAA_SRC_PANEL;
    o_cmd_src = CAA_SRC_PANEL;
    o_cmd_addr = 16'h0000;
    o_cmd_wdata = 16'h0000;
  end
  // Released lines show inverted values, never a stale request
  task automatic req(input logic rel, input caa_src_t s, output logic [1:0] ans);
    @(posedge i_clk);
    o_acq_valid <= !rel;
    o_rel_valid <= rel;
    o_acq_src <= s;
    o_rel_src <= s;
    @(posedge i_clk);
    o_acq_valid <= 1'b0;
    o_rel_valid <= 1'b0;
    o_acq_src <= caa_src_t'(~s);
    o_rel_src <= caa_src_t'(~s);
    #1;
    ans = {i_grant, i_refused};
  endtask
  task automatic cmd(input caa_src_t s, input logic w, input logic [15:0] a, input logic [15:0] d,
                     output logic [1:0] ans, output logic [15:0] rd);
    @(posedge i_clk);
    o_cmd_valid <= 1'b1;
    o_cmd_src <= s;
    o_cmd_write <= w;
    o_cmd_addr <= a;
    o_cmd_wdata <= d;
    @(posedge i_clk);
    o_cmd_valid <= 1'b0;
    o_cmd_addr <= ~a;
    o_cmd_wdata <= ~d;
    #1;
    ans = {i_ack, i_cmd_refused};
    rd = i_rdata;
  endtask
endmodule // caa_channels

// ### testbench/tb_top.sv
// Self-checking bench for the control access arbiter
`timescale 1ns/1ps
`include "caa_defines.svh"
module tb_top;
  import caa_pkg::*;
  logic i_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic i_fieldbus_mode = 1'b0;
  logic i_halt = 1'b0, i_power_removal_in_first = 1'b0, i_power_removal_in_second = 1'b0;
  logic i_stop = 1'b0;
  caa_mode_t i_mode = CAA_MODE_NONE;
  logic i_acq_valid, i_rel_valid, i_cmd_valid, i_cmd_write;
  caa_src_t i_acq_src, i_rel_src, i_cmd_src;
  logic [15:0] i_cmd_addr, i_cmd_wdata, o_cmd_rdata, o_fwd_addr, o_fwd_wdata;
  logic [15:0] o_other_channel_block, o_panel_block, rd, ad, wd;
  logic o_acq_grant, o_acq_refused, o_cmd_ack, o_cmd_refused, o_fwd_valid, o_lock_active;
  logic o_halt, o_power_removal, o_stop, o_profile_gen;
  logic [1:0] a;
  caa_owner_t o_owner;
  caa_loop_t o_loop;
  caa_ref_t o_ref_src;
  int err_total = 0, n_tests = 0, cyc = 0;

  caa_arbiter i_caa_arbiter (.*);
  caa_channels i_caa_channels (
    .i_clk(i_clk),
    .i_grant(o_acq_grant),
    .i_refused(o_acq_refused),
    .i_ack(o_cmd_ack),
    .i_cmd_refused(o_cmd_refused),
    .i_rdata(o_cmd_rdata),
    .o_acq_valid(i_acq_valid),
    .o_acq_src(i_acq_src),
    .o_rel_valid(i_rel_valid),
    .o_rel_src(i_rel_src),
    .o_cmd_valid(i_cmd_valid),
    .o_cmd_src(i_cmd_src),
    .o_cmd_write(i_cmd_write),
    .o_cmd_addr(i_cmd_addr),
    .o_cmd_wdata(i_cmd_wdata)
  );

  initial
  begin
    forever #5 i_clk = ~i_clk;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // Packs loop, profile flag and reference source as the ports show them
  function automatic logic [15:0] mode_exp(caa_mode_t m, logic fb, logic pan);
    caa_loop_t l;
    caa_ref_t r;
    l = m == CAA_MODE_CURRENT ? CAA_LOOP_CURRENT : m == CAA_MODE_SPEED ? CAA_LOOP_SPEED :
        m == CAA_MODE_NONE ? CAA_LOOP_NONE : CAA_LOOP_POSITION;
    r = (!fb || m == CAA_MODE_NONE) ? CAA_REF_NONE : m == CAA_MODE_GEAR ? CAA_REF_PULSE_INPUTS :
        (m == CAA_MODE_JOG && pan) ? CAA_REF_PANEL : CAA_REF_FIELDBUS;
    return {11'h0, l, l == CAA_LOOP_POSITION && m != CAA_MODE_GEAR, r};
  endfunction

  task automatic acq(input logic rel, input caa_src_t s, input logic [1:0] exp);
    i_caa_channels.req(rel, s, a);
    if (!rel)
      chk(16'(a), 16'(exp));
  endtask

  task automatic cmd(input caa_src_t s, input logic w, input logic [15:0] ad_i,
                     input logic [15:0] d, input logic [1:0] exp);
    i_caa_channels.cmd(s, w, ad_i, d, a, rd);
    chk(16'(a), 16'(exp));
  endtask

  // Safety inputs change at random while modes sweep
  task automatic run_modes(input logic pan);
    logic [3:0] sv;
    for (int m = 0; m < 16; m++)
    begin
      sv = 4'($urandom);
      @(posedge i_clk);
      i_mode <= caa_mode_t'(m[2:0]);
      i_fieldbus_mode <= m[3];
      {i_halt, i_power_removal_in_first, i_power_removal_in_second, i_stop} <= sv;
      @(posedge i_clk);
      #1;
      chk({11'h0, o_loop, o_profile_gen, o_ref_src}, mode_exp(caa_mode_t'(m[2:0]), m[3], pan));
      chk({13'h0, o_halt, o_power_removal, o_stop}, {13'h0, sv[3], sv[2] | sv[1], sv[0]});
    end
  endtask

  always @(posedge i_clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      err_total++;
      stop_test();
    end
  end

  initial
  begin
    void'($urandom(32'h9cde));
    repeat (5) @(posedge i_clk);
    i_rst_n <= 1'b1;
    cmd(CAA_SRC_FB, 1'b0, `CAA_OFS_OTHER_CHANNEL_BLOCK, 16'h0, 2'b10);
    chk(rd, `CAA_RST_OTHER_CHANNEL_BLOCK);
    cmd(CAA_SRC_PANEL, 1'b0, `CAA_OFS_PANEL_BLOCK, 16'h0, 2'b10);
    chk(rd, `CAA_RST_PANEL_BLOCK);
    acq(1'b0, CAA_SRC_PANEL, 2'b10);
    acq(1'b0, CAA_SRC_TOOL, 2'b01);
    acq(1'b0, CAA_SRC_FB, 2'b01);
    cmd(CAA_SRC_FB, 1'b1, 16'h0100, 16'h1234, 2'b01);
    run_modes(1'b1);
    acq(1'b1, CAA_SRC_PANEL, 2'b00);
    run_modes(1'b0);
    acq(1'b0, CAA_SRC_TOOL, 2'b10);
    acq(1'b0, CAA_SRC_PANEL, 2'b01);
    acq(1'b0, CAA_SRC_FB, 2'b01);
    cmd(CAA_SRC_PANEL, 1'b1, `CAA_OFS_PANEL_BLOCK, 16'h0001, 2'b01);
    acq(1'b1, CAA_SRC_TOOL, 2'b00);
    acq(1'b0, CAA_SRC_FB2, 2'b10);
    acq(1'b1, CAA_SRC_FB2, 2'b00);
    cmd(CAA_SRC_FB, 1'b1, `CAA_OFS_PANEL_BLOCK, 16'h0001, 2'b10);
    chk(o_panel_block, 16'h0001);
    acq(1'b0, CAA_SRC_PANEL, 2'b01);
    cmd(CAA_SRC_PANEL, 1'b1, `CAA_OFS_PANEL_BLOCK, 16'h0000, 2'b01);
    cmd(CAA_SRC_TOOL, 1'b1, `CAA_OFS_PANEL_BLOCK, 16'h0000, 2'b10);
    acq(1'b0, CAA_SRC_FB, 2'b10);
    cmd(CAA_SRC_FB, 1'b1, `CAA_OFS_OTHER_CHANNEL_BLOCK, 16'h0001, 2'b10);
    chk(16'(o_lock_active), 16'h0001);
    cmd(CAA_SRC_TOOL, 1'b0, `CAA_OFS_OTHER_CHANNEL_BLOCK, 16'h0, 2'b10);
    chk(rd, 16'h0001);
    chk(o_other_channel_block, 16'h0001);
    acq(1'b1, CAA_SRC_FB, 2'b00);
    acq(1'b0, CAA_SRC_TOOL, 2'b01);
    acq(1'b0, CAA_SRC_FB2, 2'b01);
    cmd(CAA_SRC_PANEL, 1'b1, 16'h0100, 16'h0005, 2'b01);
    @(posedge i_clk);
    i_fieldbus_mode <= 1'b0;
    acq(1'b0, CAA_SRC_TOOL, 2'b10);
    chk(16'(o_lock_active), 16'h0000);
    @(posedge i_clk);
    i_fieldbus_mode <= 1'b1;
    @(posedge i_clk);
    #1;
    chk(16'(o_owner), 16'(CAA_OWN_NONE));
    cmd(CAA_SRC_FB, 1'b1, `CAA_OFS_OTHER_CHANNEL_BLOCK, 16'h0000, 2'b10);
    cmd(CAA_SRC_TOOL, 1'b1, `CAA_OFS_OTHER_CHANNEL_BLOCK, 16'h0001, 2'b01);
    chk(o_other_channel_block, 16'h0000);
    repeat (8)
    begin
      ad = {4'h8, 12'($urandom)};
      wd = 16'($urandom);
      cmd(CAA_SRC_FB, 1'b1, ad, wd, 2'b10);
      chk(16'(o_fwd_valid), 16'h0001);
      chk(o_fwd_addr, ad);
      chk(o_fwd_wdata, wd);
    end
    stop_test();
  end
endmodule // tb_top
